//--- logic/asr_access.sv
// ascii command interpreter and register banks of the serial command port
// assumes rx_line comes straight from the pin; lookup inputs are on clock
`timescale 1ns/1ps
module asr_access
	import asr_pkg::*;
#(
	parameter int GAP_CYCLES_P = GAP_CYCLES,
	parameter int BIT_CYCLES_P = int'(BIT_CYCLES)
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire logic rx_line,
	output logic tx_line,
	output logic comm_fault,
	input wire logic [7:0] lookup_bank,
	input wire logic [15:0] lookup_id,
	output logic [31:0] lookup_data
);

	localparam logic [22:0] GAP_LAST = 23'(GAP_CYCLES_P - 1);

	logic rx_meta_reg, rx_sync_reg;
	asr_char_t rx_char;
	logic tx_busy;
	asr_state_t state_reg, state_next;
	logic write_reg, write_next;
	logic [55:0] acc_reg, acc_next;
	logic [3:0] dig_reg, dig_next;
	logic [22:0] gap_reg, gap_next;
	logic [31:0] reply_reg, reply_next;
	logic go_reg, go_next;
	logic [7:0] txd_reg, txd_next;
	logic fault_next;
	logic [31:0] lookup_next;
	logic [31:0] mem_reg [WORD_COUNT];
	logic [4:0] hv;
	logic is_crlf;
	logic [7:0] cmd_bank;
	logic [15:0] cmd_id;
	asr_bank_t cmd_info;
	logic cmd_ok;
	logic [7:0] cmd_idx;
	logic wr_en;
	logic [31:0] wr_data;
	logic [31:0] rd_word;
	asr_bank_t lk_info;
	logic [7:0] lk_idx;

	// ---------------------------------------------------------------
	// pin synchroniser and character engine
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else if (clock_enable) begin
			rx_meta_reg <= rx_line;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	asr_uart #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_uart (
		.clock(clock),
		.reset(reset),
		.clock_enable(clock_enable),
		.rx_sync(rx_sync_reg),
		.tx_go(go_reg),
		.tx_byte(txd_reg),
		.rx_char(rx_char),
		.tx_busy(tx_busy),
		.tx_line(tx_line)
	);

	// ---------------------------------------------------------------
	// command decode: one id range check serves both bank users
	// ---------------------------------------------------------------
	function automatic logic in_range(input asr_bank_t b, input logic [15:0] id);
		return b.ok && id != 16'h0000 && id <= {10'h000, b.count};
	endfunction : in_range

	always_comb begin
		hv = asr_hex_value(rx_char.data);
		is_crlf = rx_char.data == CH_CR || rx_char.data == CH_LF;
		cmd_bank = write_reg ? acc_reg[55:48] : acc_reg[23:16];
		cmd_id = write_reg ? acc_reg[47:32] : acc_reg[15:0];
		cmd_info = asr_bank_lookup(cmd_bank); // RL8 RL9 RL12 RL13 RL14 RL15
		cmd_ok = in_range(cmd_info, cmd_id); // RL19
		cmd_idx = cmd_info.base + 8'(cmd_id - 16'h0001);
		// only 16 bits exist in a torque-limit register
		wr_data = cmd_info.narrow ? {16'h0000, acc_reg[15:0]} : acc_reg[31:0]; // RL11
		rd_word = cmd_info.narrow ? {16'h0000, mem_reg[cmd_idx][15:0]} : mem_reg[cmd_idx]; // RL10
		lk_info = asr_bank_lookup(lookup_bank);
		lk_idx = lk_info.base + 8'(lookup_id - 16'h0001);
		lookup_next = in_range(lk_info, lookup_id) ? mem_reg[lk_idx] : 32'h00000000; // RL16
	end

	// ---------------------------------------------------------------
	// command parser and reply sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		write_next = write_reg;
		acc_next = acc_reg;
		dig_next = dig_reg;
		gap_next = gap_reg;
		reply_next = reply_reg;
		go_next = 1'b0;
		txd_next = txd_reg;
		fault_next = 1'b0;
		wr_en = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// the block only ever answers; it starts nothing of its own
				if (rx_char.valid && rx_char.data == CH_U) begin // RL6
					state_next = ST_PREFIX;
					gap_next = '0;
				end
			end
			ST_PREFIX: begin
				if (rx_char.valid && !is_crlf) begin // RL18
					acc_next = '0;
					dig_next = 4'h0;
					write_next = rx_char.data == CH_WRITE;
					if (rx_char.data == CH_READ || rx_char.data == CH_WRITE) begin
						state_next = ST_DIGITS;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_DIGITS: begin
				if (rx_char.valid && !is_crlf) begin // RL18
					if (hv[4]) begin
						acc_next = {acc_reg[51:0], hv[3:0]}; // RL4 RL5
						dig_next = dig_reg + 4'h1;
						if (dig_next == (write_reg ? WRITE_DIGITS : READ_DIGITS)) begin // RL7 RL20
							state_next = ST_EXEC;
						end
					end else begin
						state_next = ST_IDLE; // RL19
					end
				end
			end
			ST_EXEC: begin
				state_next = ST_IDLE;
				if (cmd_ok && write_reg) begin
					wr_en = 1'b1; // RL7
				end else if (cmd_ok) begin
					reply_next = rd_word; // RL8
					dig_next = 4'h0;
					state_next = ST_REPLY;
				end
			end
			ST_REPLY: begin
				// half duplex: characters heard while answering are dropped
				if (!tx_busy && !go_reg) begin
					if (dig_reg == REPLY_DIGITS) begin
						state_next = ST_IDLE; // RL20
					end else begin
						go_next = 1'b1;
						txd_next = asr_hex_char(reply_reg[31:28]); // RL4 RL5
						reply_next = {reply_reg[27:0], 4'h0};
						dig_next = dig_reg + 4'h1;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
		// inter-character watchdog only runs inside a command
		if (state_reg == ST_PREFIX || state_reg == ST_DIGITS) begin
			if (rx_char.valid) begin
				gap_next = '0;
			end else if (gap_reg == GAP_LAST) begin
				fault_next = 1'b1; // RL17
				state_next = ST_IDLE;
			end else begin
				gap_next = gap_reg + 23'h000001;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers and word store
	// ---------------------------------------------------------------
	// non-volatile banks are flop images here; retention lives outside
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			write_reg <= 1'b0;
			acc_reg <= '0;
			dig_reg <= '0;
			gap_reg <= '0;
			reply_reg <= '0;
			go_reg <= 1'b0;
			txd_reg <= '0;
			comm_fault <= 1'b0;
			lookup_data <= '0;
			for (int i = 0; i < WORD_COUNT; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (clock_enable) begin
			state_reg <= state_next;
			write_reg <= write_next;
			acc_reg <= acc_next;
			dig_reg <= dig_next;
			gap_reg <= gap_next;
			reply_reg <= reply_next;
			go_reg <= go_next;
			txd_reg <= txd_next;
			comm_fault <= fault_next;
			lookup_data <= lookup_next;
			if (wr_en) begin
				mem_reg[cmd_idx] <= wr_data; // RL15
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_read_exec;
		state_reg == ST_EXEC && cmd_ok && !write_reg && clock_enable;
	endsequence

	property p_crlf_ignored;
		clock_enable && rx_char.valid && is_crlf && state_reg == ST_DIGITS
			|=> $stable(acc_reg) && state_reg == ST_DIGITS;
	endproperty
	a_crlf_ignored: assert property (p_crlf_ignored) else $error("crlf altered parsing"); // RL18

	property p_nonhex_drop;
		clock_enable && state_reg == ST_DIGITS && rx_char.valid && !is_crlf && !hv[4]
			|=> state_reg == ST_IDLE;
	endproperty
	a_nonhex_drop: assert property (p_nonhex_drop) else $error("non-hex digit kept"); // RL19

	property p_bad_no_write;
		state_reg == ST_EXEC && !cmd_ok |-> !wr_en;
	endproperty
	a_bad_no_write: assert property (p_bad_no_write) else $error("bad command wrote"); // RL19

	property p_write_store;
		clock_enable && wr_en |=> mem_reg[$past(cmd_idx)] == $past(wr_data);
	endproperty
	a_write_store: assert property (p_write_store) else $error("write not stored"); // RL7

	property p_torque_low;
		wr_en && cmd_info.narrow |-> wr_data == {16'h0000, acc_reg[15:0]};
	endproperty
	a_torque_low: assert property (p_torque_low) else $error("torque high word kept"); // RL11

	property p_reply_load;
		s_read_exec |=> state_reg == ST_REPLY && dig_reg == 4'h0 && reply_reg == $past(rd_word);
	endproperty
	a_reply_load: assert property (p_reply_load) else $error("read reply not loaded"); // RL8

	property p_msb_first;
		go_reg && $past(clock_enable)
			|-> state_reg == ST_REPLY && txd_reg == asr_hex_char($past(reply_reg[31:28]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("reply digit order wrong"); // RL5

	property p_reply_eight;
		state_reg == ST_REPLY |-> dig_reg <= REPLY_DIGITS;
	endproperty
	a_reply_eight: assert property (p_reply_eight) else $error("more than eight digits"); // RL20

	property p_gap_fault;
		clock_enable && (state_reg == ST_PREFIX || state_reg == ST_DIGITS) && !rx_char.valid
			&& gap_reg == GAP_LAST
			|=> comm_fault && state_reg == ST_IDLE ##1 (!comm_fault || !$past(clock_enable));
	endproperty
	a_gap_fault: assert property (p_gap_fault) else $error("gap fault missing"); // RL17

endmodule : asr_access

//--- logic/asr_pkg.sv
// constants, types and helpers of the ascii serial register access block
// assumes a 20 MHz core clock shared with the motion program
//
// Summary of operation
// RL1 - each character: start bit, eight data, odd parity, one stop, 19200 baud
// RL2 - no hardware or software flow control on the link
// RL3 - framing and baud rate are fixed, nothing can change them
// RL4 - numeric fields in commands and answers are ascii hex digits
// RL5 - values travel most significant nibble first
// RL6 - the block is only a slave and never starts a transfer
// RL7 - write: prefix, bank code, four digit id, eight data digits; value stored
// RL8 - position banks 81 and 83, ids 1-32, read as eight hex digits
// RL9 - velocity banks 85 and 87 accept ids 1 to 16, 32-bit signed
// RL10 - torque-limit banks 89 and 8b read back 16 bits in the low word
// RL11 - torque-limit writes keep only the low 16 data bits
// RL12 - count bank 8d holds ids 1-4, count bank 8f holds id 1
// RL13 - timer bank 91 holds ids 1-8, timer bank 93 holds id 1
// RL14 - analog bank 95 holds ids 1-4, read and written alike
// RL15 - each bank exists as volatile and as non-volatile copy, own code; analog bank 95 has no non-volatile copy here
// RL16 - register values feed the motion program in place of constants
// RL17 - a 0.2 s gap inside one command raises a communication fault
// RL18 - carriage return and line feed are dropped without effect
// RL19 - bad bank, id out of range or non-hex digit discards the command
// RL20 - read: prefix, bank code, four digit id; answered by eight digits
package asr_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLOCK_HZ = 20_000_000;
	localparam int BAUD_RATE = 19_200;
	localparam logic [10:0] BIT_CYCLES = 11'((CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE); // RL3
	localparam logic [10:0] HALF_BIT_CYCLES = 11'(BIT_CYCLES / 2);
	localparam logic [3:0] FRAME_LAST = 4'ha; // parity and stop follow eight data bits
	localparam int GAP_MS = 200;
	localparam int GAP_CYCLES = GAP_MS * (CLOCK_HZ / 1000);

	// ---------------------------------------------------------------
	// characters and command lengths
	// ---------------------------------------------------------------
	localparam logic [7:0] CH_U = 8'h55;
	localparam logic [7:0] CH_READ = 8'h52;
	localparam logic [7:0] CH_WRITE = 8'h57;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_UP_A = 8'h41;
	localparam logic [7:0] CH_UP_F = 8'h46;
	localparam logic [7:0] CH_LO_A = 8'h61;
	localparam logic [7:0] CH_LO_F = 8'h66;
	localparam logic [7:0] NIB_TEN = 8'h0a;
	localparam logic [3:0] READ_DIGITS = 4'h6;
	localparam logic [3:0] WRITE_DIGITS = 4'he;
	localparam logic [3:0] REPLY_DIGITS = 4'h8;

	// ---------------------------------------------------------------
	// bank codes, sizes and places in the word store
	// ---------------------------------------------------------------
	localparam logic [7:0] BANK_POS_RAM = 8'h81;
	localparam logic [7:0] BANK_POS_NV = 8'h83;
	localparam logic [7:0] BANK_VEL_RAM = 8'h85;
	localparam logic [7:0] BANK_VEL_NV = 8'h87;
	localparam logic [7:0] BANK_TRQ_RAM = 8'h89;
	localparam logic [7:0] BANK_TRQ_NV = 8'h8b;
	localparam logic [7:0] BANK_CNT_RAM = 8'h8d;
	localparam logic [7:0] BANK_CNT_NV = 8'h8f;
	localparam logic [7:0] BANK_TMR_RAM = 8'h91;
	localparam logic [7:0] BANK_TMR_NV = 8'h93;
	localparam logic [7:0] BANK_ANA_RAM = 8'h95;
	localparam logic [5:0] SIZE_POS = 6'h20;
	localparam logic [5:0] SIZE_VEL = 6'h10;
	localparam logic [5:0] SIZE_TRQ = 6'h20;
	localparam logic [5:0] SIZE_CNT_RAM = 6'h04;
	localparam logic [5:0] SIZE_TMR_RAM = 6'h08;
	localparam logic [5:0] SIZE_ANA_RAM = 6'h04;
	localparam logic [5:0] SIZE_SINGLE = 6'h01;
	localparam logic [7:0] BASE_POS_RAM = 8'h00;
	localparam logic [7:0] BASE_POS_NV = BASE_POS_RAM + {2'h0, SIZE_POS};
	localparam logic [7:0] BASE_VEL_RAM = BASE_POS_NV + {2'h0, SIZE_POS};
	localparam logic [7:0] BASE_VEL_NV = BASE_VEL_RAM + {2'h0, SIZE_VEL};
	localparam logic [7:0] BASE_TRQ_RAM = BASE_VEL_NV + {2'h0, SIZE_VEL};
	localparam logic [7:0] BASE_TRQ_NV = BASE_TRQ_RAM + {2'h0, SIZE_TRQ};
	localparam logic [7:0] BASE_CNT_RAM = BASE_TRQ_NV + {2'h0, SIZE_TRQ};
	localparam logic [7:0] BASE_CNT_NV = BASE_CNT_RAM + {2'h0, SIZE_CNT_RAM};
	localparam logic [7:0] BASE_TMR_RAM = BASE_CNT_NV + {2'h0, SIZE_SINGLE};
	localparam logic [7:0] BASE_TMR_NV = BASE_TMR_RAM + {2'h0, SIZE_TMR_RAM};
	localparam logic [7:0] BASE_ANA_RAM = BASE_TMR_NV + {2'h0, SIZE_SINGLE};
	localparam int WORD_COUNT = int'(BASE_ANA_RAM) + int'(SIZE_ANA_RAM);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic ok;
		logic [7:0] base;
		logic [5:0] count;
		logic narrow;
	} asr_bank_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} asr_char_t;

	typedef enum logic [2:0] {ST_IDLE, ST_PREFIX, ST_DIGITS, ST_EXEC, ST_REPLY} asr_state_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic asr_bank_t asr_bank_lookup(input logic [7:0] code);
		asr_bank_t b;
		b = '0;
		case (code)
			BANK_POS_RAM: b = '{1'b1, BASE_POS_RAM, SIZE_POS, 1'b0};
			BANK_POS_NV: b = '{1'b1, BASE_POS_NV, SIZE_POS, 1'b0};
			BANK_VEL_RAM: b = '{1'b1, BASE_VEL_RAM, SIZE_VEL, 1'b0};
			BANK_VEL_NV: b = '{1'b1, BASE_VEL_NV, SIZE_VEL, 1'b0};
			BANK_TRQ_RAM: b = '{1'b1, BASE_TRQ_RAM, SIZE_TRQ, 1'b1};
			BANK_TRQ_NV: b = '{1'b1, BASE_TRQ_NV, SIZE_TRQ, 1'b1};
			BANK_CNT_RAM: b = '{1'b1, BASE_CNT_RAM, SIZE_CNT_RAM, 1'b0};
			BANK_CNT_NV: b = '{1'b1, BASE_CNT_NV, SIZE_SINGLE, 1'b0};
			BANK_TMR_RAM: b = '{1'b1, BASE_TMR_RAM, SIZE_TMR_RAM, 1'b0};
			BANK_TMR_NV: b = '{1'b1, BASE_TMR_NV, SIZE_SINGLE, 1'b0};
			BANK_ANA_RAM: b = '{1'b1, BASE_ANA_RAM, SIZE_ANA_RAM, 1'b0};
			default: b = '0;
		endcase
		return b;
	endfunction : asr_bank_lookup

	// {valid, nibble}; upper and lower case letters both accepted
	function automatic logic [4:0] asr_hex_value(input logic [7:0] c);
		if (c >= CH_ZERO && c <= CH_NINE) return {1'b1, 4'(c - CH_ZERO)};
		if (c >= CH_UP_A && c <= CH_UP_F) return {1'b1, 4'(c - CH_UP_A + NIB_TEN)};
		if (c >= CH_LO_A && c <= CH_LO_F) return {1'b1, 4'(c - CH_LO_A + NIB_TEN)};
		return 5'h00;
	endfunction : asr_hex_value

	function automatic logic [7:0] asr_hex_char(input logic [3:0] n);
		return ({4'h0, n} < NIB_TEN) ? CH_ZERO + {4'h0, n} : CH_UP_A + {4'h0, n} - NIB_TEN;
	endfunction : asr_hex_char

endpackage : asr_pkg

//--- logic/asr_uart.sv
// character receiver and transmitter of the command port
// assumes rx_sync is already synchronised to clock
`timescale 1ns/1ps
module asr_uart
	import asr_pkg::*;
#(
	parameter int BIT_CYCLES_P = int'(BIT_CYCLES)
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire logic rx_sync,
	input wire logic tx_go,
	input wire logic [7:0] tx_byte,
	output asr_char_t rx_char,
	output logic tx_busy,
	output logic tx_line
);

	// bit time is the fixed package value; a shorter one only speeds up simulation
	localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES_P - 1);
	localparam logic [10:0] HALF_LAST = 11'(BIT_CYCLES_P / 2 - 1);

	logic rx_act_reg, rx_act_next;
	logic [10:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0] rx_idx_reg, rx_idx_next;
	logic [8:0] rx_sh_reg, rx_sh_next;
	asr_char_t rx_char_next;
	logic tx_busy_next, tx_line_next;
	logic [10:0] tx_cnt_reg, tx_cnt_next;
	logic [3:0] tx_idx_reg, tx_idx_next;
	logic [9:0] tx_sh_reg, tx_sh_next;

	// ---------------------------------------------------------------
	// receiver: sample each bit in its middle
	// ---------------------------------------------------------------
	always_comb begin
		rx_act_next = rx_act_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_idx_next = rx_idx_reg;
		rx_sh_next = rx_sh_reg;
		rx_char_next = '0;
		if (!rx_act_reg) begin
			if (!rx_sync) begin
				rx_act_next = 1'b1;
				rx_cnt_next = HALF_LAST;
				rx_idx_next = 4'h0;
			end
		end else if (rx_cnt_reg != 11'h000) begin
			rx_cnt_next = rx_cnt_reg - 11'h001;
		end else begin
			rx_cnt_next = BIT_LAST;
			rx_idx_next = rx_idx_reg + 4'h1;
			if (rx_idx_reg == 4'h0) begin
				// a glitch shorter than half a bit is no start bit
				rx_act_next = !rx_sync;
			end else if (rx_idx_reg == FRAME_LAST) begin
				// fixed odd parity and one stop bit; bad frames vanish
				rx_act_next = 1'b0;
				rx_char_next.valid = rx_sync && (^rx_sh_reg); // RL1
				rx_char_next.data = rx_sh_reg[7:0];
			end else begin
				rx_sh_next = {rx_sync, rx_sh_reg[8:1]};
			end
		end
	end

	// ---------------------------------------------------------------
	// transmitter: no flow control, a character goes out as soon as asked
	// ---------------------------------------------------------------
	always_comb begin
		tx_busy_next = tx_busy;
		tx_line_next = tx_line;
		tx_cnt_next = tx_cnt_reg;
		tx_idx_next = tx_idx_reg;
		tx_sh_next = tx_sh_reg;
		if (!tx_busy) begin
			if (tx_go) begin
				tx_busy_next = 1'b1;
				tx_line_next = 1'b0;
				tx_cnt_next = BIT_LAST;
				tx_idx_next = 4'h0;
				tx_sh_next = {1'b1, ~^tx_byte, tx_byte}; // RL1 RL2
			end
		end else if (tx_cnt_reg != 11'h000) begin
			tx_cnt_next = tx_cnt_reg - 11'h001;
		end else begin
			tx_cnt_next = BIT_LAST;
			if (tx_idx_reg == FRAME_LAST) begin
				tx_busy_next = 1'b0;
				tx_line_next = 1'b1;
			end else begin
				tx_line_next = tx_sh_reg[0];
				tx_sh_next = {1'b1, tx_sh_reg[9:1]};
				tx_idx_next = tx_idx_reg + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_act_reg <= 1'b0;
			rx_cnt_reg <= '0;
			rx_idx_reg <= '0;
			rx_sh_reg <= '0;
			rx_char <= '0;
			tx_busy <= 1'b0;
			tx_line <= 1'b1;
			tx_cnt_reg <= '0;
			tx_idx_reg <= '0;
			tx_sh_reg <= '0;
		end else if (clock_enable) begin
			rx_act_reg <= rx_act_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_idx_reg <= rx_idx_next;
			rx_sh_reg <= rx_sh_next;
			rx_char <= rx_char_next;
			tx_busy <= tx_busy_next;
			tx_line <= tx_line_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_idx_reg <= tx_idx_next;
			tx_sh_reg <= tx_sh_next;
		end
	end

endmodule : asr_uart

//--- verif/asr_master.sv
// serial master model: sends command characters, collects reply characters
// assumes the device line timing of asr_pkg and a shared core clock
`timescale 1ns/1ps
module asr_master
	import asr_pkg::*;
#(
	parameter int BIT_P = int'(BIT_CYCLES)
)
(
	input wire logic clock,
	input wire logic tx_line,
	output logic rx_line
);
	// idle line sits high, no handshake lines exist at all
	initial rx_line = 1'b1;

	// ---------------------------------------------------------------
	// transmit one framed character
	// ---------------------------------------------------------------
	task automatic send_char(input logic [7:0] c);
		logic [10:0] f;
		f = {1'b1, ~^c, c, 1'b0};
		// finish the stop bit that the previous character left short
		repeat (BIT_P - BIT_P / 2) @(posedge clock);
		for (int i = 0; i < 11; i++) begin
			@(posedge clock);
			rx_line <= f[i];
			// return in mid stop bit, so a reply start bit is never missed
			repeat ((i == 10) ? BIT_P / 2 : BIT_P - 1) @(posedge clock);
		end
	endtask : send_char

	// gapless, so the device never sees a pause inside one command
	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_char(s[i]);
		end
	endtask : send_str

	// ---------------------------------------------------------------
	// receive one character; ok means start, odd parity and stop held
	// ---------------------------------------------------------------
	task automatic recv_char(output logic [7:0] c, output logic ok);
		logic [10:0] f;
		int n;
		n = 0;
		c = 8'h00;
		while (tx_line !== 1'b0 && n < 40000) begin
			@(posedge clock);
			n++;
		end
		repeat (BIT_P / 2) @(posedge clock);
		f[0] = tx_line;
		for (int i = 1; i < 11; i++) begin
			repeat (BIT_P) @(posedge clock);
			f[i] = tx_line;
		end
		c = f[8:1];
		ok = (n < 40000) && (f[0] === 1'b0) && (f[10] === 1'b1) && (^f[9:1] === 1'b1);
	endtask : recv_char
endmodule : asr_master

//--- verif/ascii_serial_register_access_tb.sv
// testbench of the ascii serial register access block
// assumes the serial master model; gap and bit time shortened for run time
`timescale 1ns/1ps
module ascii_serial_register_access_tb
	import asr_pkg::*;
;
	localparam int GAP_SIM = 600; // must exceed one character time
	localparam int BIT_SIM = 32; // short bit keeps the run brief
	logic clock;
	logic reset;
	logic clock_enable;
	logic rx_line;
	logic tx_line;
	logic comm_fault;
	logic [7:0] lookup_bank;
	logic [15:0] lookup_id;
	logic [31:0] lookup_data;
	int err_count;
	int checked;

	asr_access #(.GAP_CYCLES_P(GAP_SIM), .BIT_CYCLES_P(BIT_SIM)) dut (
		.clock(clock),
		.reset(reset),
		.clock_enable(clock_enable),
		.rx_line(rx_line),
		.tx_line(tx_line),
		.comm_fault(comm_fault),
		.lookup_bank(lookup_bank),
		.lookup_id(lookup_id),
		.lookup_data(lookup_data)
	);

	asr_master #(.BIT_P(BIT_SIM)) m (
		.clock(clock),
		.tx_line(tx_line),
		.rx_line(rx_line)
	);

	// ---------------------------------------------------------------
	// clock, compare and closing
	// ---------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// motion-side lookup: registered, valid one cycle after bank/id
	task automatic lk(input logic [7:0] b, input logic [15:0] id, input logic [31:0] exp);
		// let a write that just ended land in the store first
		repeat (8) @(posedge clock);
		lookup_bank <= b;
		lookup_id <= id;
		repeat (2) @(posedge clock);
		#1 check(lookup_data, exp);
	endtask : lk

	// read command over the link; reply must be eight framed hex chars
	task automatic rd(input string cmd, input string exp);
		logic [7:0] c;
		logic ok;
		m.send_str(cmd);
		for (int i = 0; i < 8; i++) begin
			m.recv_char(c, ok);
			check({24'h0, c}, {24'h0, exp[i]});
			check({31'h0, ok}, 32'h1);
		end
	endtask : rd

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// a lone prefix then silence must raise one fault pulse
	task automatic t_gap();
		int n;
		n = 0;
		m.send_char(8'h55);
		while (comm_fault !== 1'b1 && n < GAP_SIM + 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		check({31'h0, comm_fault}, 32'h1);
		@(posedge clock);
		#1 check({31'h0, comm_fault}, 32'h0);
	endtask : t_gap

	// position write, then read back most significant digit first
	task automatic t_position();
		m.send_str("UW83001100001F40");
		lk(8'h83, 16'h0011, 32'h0000_1f40);
		rd("UR830011", "00001F40");
	endtask : t_position

	// torque write with cr/lf inside: low word kept, high word read as zero
	task automatic t_torque();
		m.send_str("UW8B0001");
		m.send_char(8'h0d);
		m.send_char(8'h0a);
		m.send_str("abcd1234");
		lk(8'h8b, 16'h0001, 32'h0000_1234);
		rd("UR8B0001", "00001234");
	endtask : t_torque

	// id beyond a single-word bank must not touch anything
	task automatic t_bad_id();
		m.send_str("UW8F0002FFFFFFFF");
		lk(8'h8f, 16'h0001, 32'h0000_0000);
		lk(8'h97, 16'h0001, 32'h0000_0000);
		lk(8'h81, 16'h0001, 32'h0000_0000);
		lk(8'h91, 16'h0001, 32'h0000_0000);
	endtask : t_bad_id

	// top ids of banks 85, 8d, 91 and 95, one id past velocity, and a frozen lookup
	task automatic t_banks();
		m.send_str("UW8500107FFFFFFF");
		lk(8'h85, 16'h0010, 32'h7fff_ffff);
		m.send_str("UW8500110000000F");
		lk(8'h87, 16'h0001, 32'h0000_0000);
		m.send_str("UW8D000489ABCDEF");
		lk(8'h8d, 16'h0004, 32'h89ab_cdef);
		m.send_str("UW9100080000ABCD");
		lk(8'h91, 16'h0008, 32'h0000_abcd);
		m.send_str("UW950004FFFFFFFE");
		lk(8'h95, 16'h0004, 32'hffff_fffe);
		@(posedge clock);
		clock_enable <= 1'b0;
		lookup_bank <= 8'h8d;
		lookup_id <= 16'h0004;
		repeat (3) @(posedge clock);
		#1 check(lookup_data, 32'hffff_fffe);
		@(posedge clock);
		clock_enable <= 1'b1;
		lk(8'h8d, 16'h0004, 32'h89ab_cdef);
	endtask : t_banks

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		err_count = 0;
		checked = 0;
		reset = 1'b1;
		clock_enable = 1'b1;
		lookup_bank = 8'h00;
		lookup_id = 16'h0000;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		check({31'h0, tx_line}, 32'h1);
		t_gap();
		t_position();
		t_torque();
		t_bad_id();
		t_banks();
		report_and_stop();
	end

	// a full run is about 170 short characters, some 62000 clocks
	initial begin
		repeat (90_000) @(posedge clock);
		err_count++;
		report_and_stop();
	end
endmodule : ascii_serial_register_access_tb
